/* File: design/sarr_pkg.sv */
// =============================================
// Shared constants for the serial result readout
package sarr_pkg;
	// =============================================
	// Word layout
	localparam int RESULT_W = 12;
	localparam int XFER_BITS = 8;
	localparam int XFER_COUNT = 2;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
	// Clock numbers (counted on rising edges) that mark the frame
	localparam logic [CNT_W-1:0] CLK_NULL = 5'h02;
	localparam logic [CNT_W-1:0] CLK_MSB = 5'h03;
	localparam logic [CNT_W-1:0] CLK_LSB = 5'h0e;
	localparam logic [CNT_W-1:0] CLK_LSB_FIRST_END = 5'h19;
	// =============================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_HALF_CYC = 16;
	localparam logic [4:0] SCLK_HALF_LAST = 5'(SCLK_HALF_CYC - 1);
	localparam int HOLD_LIMIT_NS = 1200000;
	localparam int HOLD_LIMIT_CYC = HOLD_LIMIT_NS / CLK_PERIOD_NS;
	localparam int HOLD_CNT_W = 17;
	// =============================================
	// Reset values
	localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
	localparam logic [2:0] SYNC_RST = 3'h0;

	// Three-stage filter: accept a new level once stages two and three agree
	function automatic logic lvl_next(input logic s2, input logic s3, input logic lvl);
		lvl_next = (s2 == s3) ? s2 : lvl;
	endfunction : lvl_next

	// Realign two received bytes into the result word
	function automatic logic [RESULT_W-1:0] realign(input logic [7:0] hi, input logic [7:0] lo);
		logic [7:0] loFix;
		logic [7:0] hiFix;
		loFix = {hi[0], lo[7:1]};
		hiFix = {1'b0, hi[7:1]};
		realign = {hiFix[3:0], loFix};
	endfunction : realign
endpackage : sarr_pkg

/* File: design/sarr_link_if.sv */
`timescale 1ns/1ps
// =============================================
// Serial link between host and converter
interface sarr_link_if;
	logic sclk;
	logic selectAndStandbyN;
	logic dataOutVal;
	logic dataOutEn;
	logic dataLine;

	// Undriven line reads high, as through a pull-up
	assign dataLine = dataOutEn ? dataOutVal : 1'b1;

	modport conv (
		input sclk,
		input selectAndStandbyN,
		output dataOutVal,
		output dataOutEn
	);
	modport host (
		output sclk,
		output selectAndStandbyN,
		input dataLine
	);
endinterface : sarr_link_if

/* File: design/sarr_converter.sv */
`timescale 1ns/1ps
module sarr_converter (
	input wire logic clk,
	input wire logic rst,
	sarr_link_if.conv link,
	input wire logic [sarr_pkg::RESULT_W-1:0] sampleIn,
	output logic standby,
	output logic acquiring,
	output logic convDone,
	output logic [sarr_pkg::RESULT_W-1:0] convWord
);
	import sarr_pkg::*;

	// =============================================
	// Pin synchronisers
	// Reset levels match a deselected link; in idle-high mode a false rise
	// follows reset, harmless because select is still high then
	logic [2:0] sclkSync_reg;
	logic [2:0] selSync_reg;
	logic sclkLvl_reg;
	logic selLvl_reg;
	logic sclkLvl_next;
	logic selLvl_next;

	// Three flops per pin; only stages two and three are looked at
	// A level that flips for a single cycle never reaches the edge finders
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sclkSync_reg <= SYNC_RST;
			selSync_reg <= 3'h7;
			sclkLvl_reg <= 1'b0;
			selLvl_reg <= 1'b1;
		end
		else
		begin
			sclkSync_reg <= {sclkSync_reg[1:0], link.sclk};
			selSync_reg <= {selSync_reg[1:0], link.selectAndStandbyN};
			sclkLvl_reg <= sclkLvl_next;
			selLvl_reg <= selLvl_next;
		end
	end

	// Edge finding on filtered levels; no period or duty assumed
	assign sclkLvl_next = lvl_next(sclkSync_reg[1], sclkSync_reg[2], sclkLvl_reg);
	assign selLvl_next = lvl_next(selSync_reg[1], selSync_reg[2], selLvl_reg);
	wire sclkRise = sclkLvl_next & ~sclkLvl_reg;
	wire sclkFall = ~sclkLvl_next & sclkLvl_reg;
	wire selected = ~selLvl_reg;

	// =============================================
	// Clock counter
	logic [CNT_W-1:0] clkNum_reg;
	logic [CNT_W-1:0] clkNum_next;

	// Counting rising edges makes a leading falling edge in idle-high mode harmless
	// Saturates at the top so a runaway host cannot wrap into a new frame
	assign clkNum_next = !selected ? '0 :
		(sclkRise && clkNum_reg != CNT_MAX) ? clkNum_reg + 5'h01 : clkNum_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			clkNum_reg <= '0;
		else
			clkNum_reg <= clkNum_next; // Cleared while deselected
	end

	// =============================================
	// Helpers
	// Guarded bit pick; an index past the word reads zero instead of unknown
	function automatic logic pick_bit(
		input logic [RESULT_W-1:0] word,
		input logic [3:0] idx
	);
		pick_bit = (idx < 4'(RESULT_W)) ? word[idx] : 1'b0;
	endfunction : pick_bit

	// =============================================
	// Bit selection
	// Frame map by rising-edge count: 2 null, 3..14 MSB first, 15..25 reversed
	logic [RESULT_W-1:0] word_reg;
	wire inMsb = (clkNum_reg >= CLK_MSB) && (clkNum_reg <= CLK_LSB);
	wire inLsbFirst = (clkNum_reg > CLK_LSB) && (clkNum_reg <= CLK_LSB_FIRST_END);
	// MSB at clock three, index falls by one per clock
	wire [3:0] msbIdx = 4'(CLK_LSB - clkNum_reg);
	// Reverse copy starts at bit one, bit zero is shared
	wire [3:0] lsbIdx = 4'(clkNum_reg - CLK_LSB);
	// Both picks share one guarded helper
	wire msbBit = pick_bit(word_reg, msbIdx);
	wire lsbBit = pick_bit(word_reg, lsbIdx);
	// Anything past the reverse copy reads zero
	wire nextBit = inMsb ? msbBit :
		inLsbFirst ? lsbBit :
		1'b0;
	wire atNull = clkNum_reg == CLK_NULL;
	wire drivenPhase = clkNum_reg >= CLK_NULL;

	// =============================================
	// Serial output, updated on falling edges only
	// Value and enable move together so the line never shows a stale bit
	// Deselect wins over a falling edge in the same cycle
	logic dataVal_reg;
	logic dataEn_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			dataVal_reg <= 1'b0;
			dataEn_reg <= 1'b0;
		end
		else if (!selected)
		begin
			dataVal_reg <= 1'b0; // Float while deselected
			dataEn_reg <= 1'b0;
		end
		else if (sclkFall && drivenPhase)
		begin
			dataEn_reg <= 1'b1; // Stays off through clock one, comes on at the fall of clock two
			dataVal_reg <= atNull ? 1'b0 : nextBit; // Null bit first
		end
	end

	assign link.dataOutVal = dataVal_reg;
	assign link.dataOutEn = dataEn_reg;

	// =============================================
	// Sample capture and status
	logic acq_reg;
	logic done_reg;
	logic standby_reg;

	// Held word stands in for the charge on the hold capacitor
	// Later changes of the input are ignored until the next frame
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			word_reg <= RESULT_RST;
		else if (selected && sclkFall && atNull)
			word_reg <= sampleIn; // Sampling ends here
	end

	// Acquire from first rising edge to falling of clock two
	// Cleared on deselect so a cut frame never leaves it high
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			acq_reg <= 1'b0;
		else if (!selected)
			acq_reg <= 1'b0;
		else if (sclkRise && clkNum_reg == '0)
			acq_reg <= 1'b1;
		else if (sclkFall && atNull)
			acq_reg <= 1'b0;
	end

	// One-cycle pulse when the LSB has gone out
	// Limitation: a frame cut before the LSB gives no pulse
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			done_reg <= 1'b0;
		else
			done_reg <= selected && sclkFall && (clkNum_reg == CLK_LSB);
	end

	// Standby whenever deselected
	// Registered so the port comes straight from a flop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			standby_reg <= 1'b1;
		else
			standby_reg <= ~selected;
	end

	// Result word mirrors the held sample
	// One cycle behind the held word, traded for a flop-driven port
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			convWord <= RESULT_RST;
		else
			convWord <= word_reg;
	end

	assign standby = standby_reg;
	assign acquiring = acq_reg;
	assign convDone = done_reg;
endmodule : sarr_converter

/* File: design/sarr_host.sv */
`timescale 1ns/1ps
module sarr_host #(
	parameter int HOLD_CYC = sarr_pkg::HOLD_LIMIT_CYC
) (
	input wire logic clk,
	input wire logic rst,
	sarr_link_if.host link,
	input wire logic runEnable,
	input wire logic idleHigh,
	output logic busy,
	output logic lateFlag,
	output logic resultValid,
	input wire logic resultReady,
	output logic [sarr_pkg::RESULT_W-1:0] resultData
);
	import sarr_pkg::*;

	typedef enum {ST_IDLE, ST_LEAD, ST_BITS, ST_GAP, ST_TRAIL} sarr_state_e;

	// =============================================
	// State
	sarr_state_e state_reg;
	logic [4:0] halfCnt_reg;
	logic [3:0] bitCnt_reg;
	logic phase_reg;
	logic mode_reg;
	logic sclk_reg;
	logic sel_reg;
	logic [15:0] shift_reg;
	logic [2:0] dSync_reg;
	logic dLvl_reg;
	logic [HOLD_CNT_W-1:0] hold_reg;
	logic holdRun_reg;
	logic late_reg;
	logic [RESULT_W-1:0] head_reg;
	logic [RESULT_W-1:0] tail_reg;
	logic headV_reg;
	logic tailV_reg;

	// Decoding
	wire halfEnd = halfCnt_reg == SCLK_HALF_LAST;
	wire fifoRoom = ~tailV_reg; // Only start when the word will fit
	// Clock must rest at the chosen idle level first, so no edge meets select
	wire startOk = runEnable && fifoRoom && (sclk_reg == idleHigh);
	// Rising edge is the first half in idle-low mode, second in idle-high
	wire riseNow = halfEnd && (phase_reg == mode_reg);
	wire lastBit = bitCnt_reg[2:0] == 3'h7;
	wire pushWord = (state_reg == ST_TRAIL) && halfEnd && sel_reg == 1'b0;
	wire [RESULT_W-1:0] newWord = realign(shift_reg[15:8], shift_reg[7:0]);
	wire popWord = headV_reg && resultReady;

	// Data line filter
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			dSync_reg <= SYNC_RST;
			dLvl_reg <= 1'b0;
		end
		else
		begin
			dSync_reg <= {dSync_reg[1:0], link.dataLine};
			dLvl_reg <= lvl_next(dSync_reg[1], dSync_reg[2], dLvl_reg);
		end
	end

	// =============================================
	// Transfer sequencer; divider makes the link clock
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			halfCnt_reg <= '0;
			bitCnt_reg <= '0;
			phase_reg <= 1'b0;
			mode_reg <= 1'b0;
			sclk_reg <= 1'b0;
			sel_reg <= 1'b1;
			shift_reg <= '0;
		end
		else
		begin
			halfCnt_reg <= halfEnd ? 5'h00 : halfCnt_reg + 5'h01;
			unique case (state_reg)
				ST_IDLE:
				begin
					sclk_reg <= idleHigh; // Either idle level
					if (startOk && halfEnd)
					begin
						mode_reg <= idleHigh;
						sel_reg <= 1'b0;
						bitCnt_reg <= '0;
						phase_reg <= 1'b0;
						state_reg <= ST_LEAD;
					end
				end
				ST_LEAD:
					if (halfEnd)
						state_reg <= ST_BITS;
				ST_BITS:
					if (halfEnd)
					begin
						sclk_reg <= ~sclk_reg;
						phase_reg <= ~phase_reg;
						if (riseNow)
							shift_reg <= {shift_reg[14:0], dLvl_reg}; // Capture on rise
						if (phase_reg)
						begin
							bitCnt_reg <= bitCnt_reg + 4'h1;
							if (lastBit)
								state_reg <= bitCnt_reg[3] ? ST_TRAIL : ST_GAP;
						end
					end
				ST_GAP:
					if (halfEnd)
						state_reg <= ST_BITS; // Select stays low between bytes
				ST_TRAIL:
					if (halfEnd)
					begin
						if (!sel_reg)
							sel_reg <= 1'b1; // Deselect between conversions
						else
							state_reg <= ST_IDLE;
					end
			endcase
		end
	end

	assign link.sclk = sclk_reg;
	assign link.selectAndStandbyN = sel_reg;

	// =============================================
	// Watchdog on the hold time of the sampled charge
	// Runs from end of clock two to the LSB capture
	wire holdStart = (state_reg == ST_BITS) && phase_reg && halfEnd && bitCnt_reg == 4'h1;
	wire holdStop = (state_reg == ST_BITS) && riseNow && bitCnt_reg == 4'he;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hold_reg <= '0;
			holdRun_reg <= 1'b0;
			late_reg <= 1'b0;
		end
		else
		begin
			if (holdStart)
				holdRun_reg <= 1'b1;
			else if (holdStop)
				holdRun_reg <= 1'b0;
			hold_reg <= holdStart ? '0 : (holdRun_reg ? hold_reg + 17'h00001 : hold_reg);
			if (holdStop)
				late_reg <= (32'(hold_reg) >= HOLD_CYC);
		end
	end

	// =============================================
	// Two-entry result buffer; head is the output
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			head_reg <= RESULT_RST;
			tail_reg <= RESULT_RST;
			headV_reg <= 1'b0;
			tailV_reg <= 1'b0;
		end
		else
		begin
			if (popWord)
			begin
				headV_reg <= tailV_reg || pushWord;
				head_reg <= tailV_reg ? tail_reg : newWord;
				tailV_reg <= tailV_reg && pushWord;
				if (tailV_reg && pushWord)
					tail_reg <= newWord;
			end
			else if (pushWord)
			begin
				if (!headV_reg)
				begin
					head_reg <= newWord;
					headV_reg <= 1'b1;
				end
				else
				begin
					tail_reg <= newWord;
					tailV_reg <= 1'b1;
				end
			end
		end
	end

	// Busy mirrors a registered state flag
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			busy <= 1'b0;
		else
			busy <= (state_reg != ST_IDLE);
	end

	assign lateFlag = late_reg;
	assign resultValid = headV_reg;
	assign resultData = head_reg;
endmodule : sarr_host

/* File: dv/sarr_link_checker.sv */
`timescale 1ns/1ps
// =============================================
// Wire-level checker beside the link between both ends
module sarr_link_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic selectAndStandbyN,
	input wire logic dataOutVal,
	input wire logic dataOutEn,
	input wire logic dataLine
);
	logic sclkQ;
	logic [4:0] riseCnt;
	logic [4:0] sinceFall;
	logic [11:0] msbBits;
	wire logic sclkRise;
	wire logic sclkFall;
	wire logic msbWindow;

	// Link edges seen from the system clock
	assign sclkRise = sclk && !sclkQ;
	assign sclkFall = !sclk && sclkQ;
	assign msbWindow = sclkRise && (riseCnt inside {[5'h03:5'h0e]});

	// Rising edges per frame; deselect restarts the count
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sclkQ <= 1'b0;
			riseCnt <= 5'h00;
		end
		else
		begin
			sclkQ <= sclk;
			riseCnt <= selectAndStandbyN ? 5'h00 : riseCnt + 5'(sclkRise);
		end
	end

	// Age of last falling edge; MSB-first bits kept for the mirror copy
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sinceFall <= 5'h1f;
			msbBits <= 12'h000;
		end
		else
		begin
			sinceFall <= sclkFall ? 5'h00 : sinceFall + 5'(sinceFall != 5'h1f);
			if (msbWindow)
				msbBits[5'h0e - riseCnt] <= dataLine;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_float_on_deselect: assert property (
		$rose(selectAndStandbyN) |-> ##[1:8] !dataOutEn)
		else $error("data line still driven after deselect");
	a_data_on_fall: assert property (
		dataOutEn && $past(dataOutEn) && $changed(dataOutVal) |-> sinceFall <= 5'h08)
		else $error("data changed away from a falling edge");
	a_early_undriven: assert property (
		(!selectAndStandbyN && riseCnt < 5'h02) [*8] |-> !dataOutEn)
		else $error("data driven during first two clocks");
	a_null_bit: assert property (
		sclkRise && riseCnt == 5'h02 |-> dataOutEn && !dataLine)
		else $error("null bit missing");
	a_driven_in_frame: assert property (
		sclkRise && (riseCnt inside {[5'h03:5'h0f]}) |-> dataOutEn)
		else $error("result bit not driven");
	a_lsb_mirror: assert property (
		sclkRise && riseCnt == 5'h0f |-> dataLine == msbBits[1])
		else $error("repeated bit one wrong");
	a_sixteen_clocks: assert property (
		$rose(selectAndStandbyN) |-> riseCnt == 5'h10)
		else $error("frame not two 8-clock transfers");
	a_half_period: assert property (
		!selectAndStandbyN && $changed(sclk) |=> $stable(sclk) [*8])
		else $error("link clock half period too short");
endmodule : sarr_link_checker

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
// =============================================
// Bench: host and converter face each other
module tb_top;
	import sarr_pkg::*;
	// Small hold limit keeps the run short, still above one frame
	localparam int HOLD_SIM = 1000;
	logic clk;
	logic rst;
	logic [RESULT_W-1:0] sampleIn;
	logic runEnable;
	logic idleHigh;
	logic resultReady;
	logic busy;
	logic lateFlag;
	logic resultValid;
	logic standby;
	logic [RESULT_W-1:0] resultData;
	logic acquiring;
	logic convDone;
	logic [RESULT_W-1:0] convWord;
	logic acqQ;
	int doneCount;
	int acqCount;
	int mismatches;
	int checksDone;

	sarr_link_if link ();
	sarr_converter sarr_converter_i (.clk(clk), .rst(rst), .link(link.conv),
		.sampleIn(sampleIn), .standby(standby), .acquiring(acquiring), .convDone(convDone),
		.convWord(convWord));
	sarr_host #(.HOLD_CYC(HOLD_SIM)) sarr_host_i (.clk(clk), .rst(rst), .link(link.host),
		.runEnable(runEnable), .idleHigh(idleHigh), .busy(busy), .lateFlag(lateFlag),
		.resultValid(resultValid), .resultReady(resultReady), .resultData(resultData));
	sarr_link_checker sarr_link_checker_i (.clk(clk), .rst(rst), .sclk(link.sclk),
		.selectAndStandbyN(link.selectAndStandbyN), .dataOutVal(link.dataOutVal),
		.dataOutEn(link.dataOutEn), .dataLine(link.dataLine));

	// =============================================
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Status watchers: count done pulses and acquire starts
	always @(posedge clk)
	begin
		acqQ <= acquiring;
		if (convDone === 1'b1)
			doneCount <= doneCount + 1;
		if (acquiring === 1'b1 && acqQ !== 1'b1)
			acqCount <= acqCount + 1;
	end

	// =============================================
	// Compare and wait helpers
	task automatic check_word(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_bit(input logic got, input logic exp);
		checksDone++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_bit

	// Bounded wait; a level never reached shows as a mismatch
	task automatic wait_for(ref logic sig, input logic lvl);
		int n;
		n = 0;
		while (sig !== lvl && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
		check_bit(sig, lvl);
	endtask : wait_for

	// Take one word from the buffer; ready held for exactly one edge
	task automatic pop_word(input logic [RESULT_W-1:0] exp);
		wait_for(resultValid, 1'b1);
		check_word(resultData, exp);
		@(posedge clk) resultReady <= 1'b1;
		@(posedge clk) resultReady <= 1'b0;
	endtask : pop_word

	// =============================================
	// Scenarios
	// Both idle levels, edge codes, one conversion each
	task automatic test_modes();
		logic [RESULT_W-1:0] vals [4] = '{12'ha5c, 12'h000, 12'hfff, 12'h801};
		int doneSeen;
		int acqSeen;
		for (int m = 0; m < 2; m++)
			for (int k = 0; k < 4; k++)
			begin
				@(posedge clk);
				doneSeen = doneCount;
				acqSeen = acqCount;
				sampleIn <= vals[k];
				idleHigh <= (m == 1);
				runEnable <= 1'b1;
				wait_for(busy, 1'b1);
				@(posedge clk) runEnable <= 1'b0;
				pop_word(vals[k]);
				check_bit(lateFlag, 1'b0);
				wait_for(busy, 1'b0);
				check_bit(standby, 1'b1);
				check_word(convWord, vals[k]);
				check_bit(acquiring, 1'b0);
				check_word(12'(doneCount - doneSeen), 12'h001);
				check_word(12'(acqCount - acqSeen), 12'h001);
			end
	endtask : test_modes

	// Receiver stalls: two frames fill the buffer, then no third frame
	task automatic test_fill();
		@(posedge clk);
		idleHigh <= 1'b0;
		sampleIn <= 12'h3c7;
		runEnable <= 1'b1;
		wait_for(standby, 1'b0);
		wait_for(standby, 1'b1);
		@(posedge clk) sampleIn <= 12'h458;
		wait_for(standby, 1'b0);
		wait_for(standby, 1'b1);
		repeat (800) @(negedge clk);
		check_bit(standby, 1'b1);
		@(posedge clk) runEnable <= 1'b0;
		pop_word(12'h3c7);
		repeat (5) @(posedge clk);
		pop_word(12'h458);
		@(negedge clk);
		check_bit(resultValid, 1'b0);
	endtask : test_fill

	// Reset in mid-frame, then a fresh conversion
	task automatic test_reset();
		@(posedge clk);
		sampleIn <= 12'h6b2;
		runEnable <= 1'b1;
		wait_for(standby, 1'b0);
		repeat (200) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check_bit(link.dataLine, 1'b1);
		check_bit(resultValid, 1'b0);
		check_word(convWord, RESULT_RST);
		wait_for(busy, 1'b1);
		@(posedge clk) runEnable <= 1'b0;
		pop_word(12'h6b2);
		check_word(convWord, 12'h6b2);
	endtask : test_reset

	// =============================================
	// Verdict
	task automatic print_verdict();
		$display("Checks: %0d, mismatches: %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	// Main sequence
	initial
	begin
		rst = 1'b1;
		sampleIn = 12'h000;
		runEnable = 1'b0;
		idleHigh = 1'b0;
		resultReady = 1'b0;
		mismatches = 0;
		checksDone = 0;
		acqQ = 1'b0;
		doneCount = 0;
		acqCount = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		test_modes();
		test_fill();
		test_reset();
		print_verdict();
	end

	// Watchdog: about five times the expected run
	initial
	begin
		repeat (40000) @(posedge clk);
		mismatches++;
		print_verdict();
	end
endmodule : tb_top
